// >>> logic/voice_codec_pkg.sv
package voice_codec_pkg;

  // ************************************************************
  // register indices (address byte bits 6..3)
  // ************************************************************
  localparam int unsigned NUM_REGS = 11;
  localparam logic [3:0] IDX_CLOCK_LAW = 4'h0;
  localparam logic [3:0] IDX_CHANNEL_PATH = 4'h1;
  localparam logic [3:0] IDX_RX_SUBST = 4'h2;
  localparam logic [3:0] IDX_TX_SUBST = 4'h3;
  localparam logic [3:0] IDX_ROUTING = 4'h4;
  localparam logic [3:0] IDX_TX_SIDETONE = 4'h5;
  localparam logic [3:0] IDX_EAR_SPEAKER = 4'h6;
  localparam logic [3:0] IDX_TONE_SHAPE = 4'h7;
  localparam logic [3:0] IDX_TONE_ONE = 4'h8;
  localparam logic [3:0] IDX_TONE_TWO = 4'h9;
  localparam logic [3:0] IDX_BOOST_CLIP = 4'hA;

  // ************************************************************
  // address byte layout
  // ************************************************************
  localparam int unsigned ADDR_POWER_BIT = 7;
  localparam int unsigned ADDR_IDX_MSB = 6;
  localparam int unsigned ADDR_IDX_LSB = 3;
  localparam int unsigned ADDR_READ_BIT = 2;
  localparam int unsigned ADDR_SECOND_BIT = 1;
  localparam logic [3:0] LAST_ADDR_BIT = 4'h7;
  localparam logic [3:0] LAST_DATA_BIT = 4'hF;

  // ************************************************************
  // values after reset
  // ************************************************************
  localparam logic [7:0] RST_CLOCK_LAW = 8'h40;
  localparam logic [7:0] RST_BOOST_CLIP = 8'hC0;
  localparam logic [7:0] RST_OTHER = 8'h00;
  localparam logic RST_POWER_DOWN = 1'b1;
  // synchronisers start with select deasserted and every other pin low
  localparam logic [5:0] RST_PINS = 6'h10;

  // ************************************************************
  // pcm framing
  // ************************************************************
  localparam logic [7:0] SLOT_BITS = 8'h08;
  localparam logic [7:0] SLOT_GAP_BITS = 8'h02;
  localparam logic [2:0] SLOT_LAST_BIT = 3'h7;

  // master clock to 8 kHz frame divider per clock select code
  localparam logic [8:0] DIV_512K = 9'h040;
  localparam logic [8:0] DIV_1536K = 9'h0C0;
  localparam logic [8:0] DIV_2048K = 9'h100;
  localparam logic [8:0] DIV_2560K = 9'h140;

  typedef enum logic [1:0] {
    LAW_MU255, LAW_MU_BARE, LAW_A_EVEN_INV, LAW_A_BARE
  } law_type;

  typedef enum logic [1:0] {
    RANGE_STANDARD, RANGE_HALF, RANGE_DOUBLE
  } tone_range_type;

  typedef struct packed {
    logic cclk;
    logic cs_n;
    logic ci;
  } serial_pins_type;

  typedef struct packed {
    logic mclk;
    logic fs;
    logic dr;
  } pcm_pins_type;

  typedef struct packed {
    logic mic_select;
    logic transmit_input_enable;
    logic sidetone_on;
    logic aux_input_enable;
    logic tone_to_speaker;
    logic tone_to_earpiece;
    logic speech_to_speaker;
    logic speech_to_earpiece;
    logic [3:0] transmit_gain;
    logic [3:0] sidetone_atten;
    logic [3:0] earpiece_gain;
    logic [3:0] speaker_gain;
    logic speaker_boost;
    logic handsfree_io_enable;
    logic antilarsen_enable;
  } audio_ctrl_type;

  typedef struct packed {
    logic [3:0] tone_gain;
    logic tone_one_on;
    logic tone_two_on;
    logic sine_select;
    logic tone_to_transmit;
    logic [7:0] tone_one_number;
    logic [7:0] tone_two_number;
    tone_range_type tone_range;
    logic anticlip_enable;
    logic [1:0] clip_threshold;
    logic [1:0] release_time;
  } tone_clip_type;

endpackage : voice_codec_pkg

// >>> logic/voice_codec_control.sv
// Contract
// R1 - speaker boost bit selects +27 dB loudspeaker path when 1, +9 dB when 0
// R2 - anticlip enable bit turns the anti-clipping section on or off
// R3 - threshold field codes 00..11 give -15, -13, -9, -7 dBm0; default 00
// R4 - release field codes 00..11 give 256, 128, 32, 16 ms; default 00
// R5 - range bits: 00 standard, 01 halved, 10 doubled; 11 never written
// R6 - each tone frequency register holds an 8-bit unsigned number, msb bit 7
// R7 - tone-to-transmit bit routes the tone generator into the transmit path
// R8 - clock select codes 00..11 pick divider for 512k, 1.536M, 2.048M, 2.56M
// R9 - in gci mode controller uses only 1.536 or 2.048 MHz master clock
// R10 - clock default 1.536 MHz; other clocks written before power-up
// R11 - law bits pick mu-255, mu bare, A even-inverted, A bare; mu-255 default
// R12 - every pcm byte shifts msb first, transmit and receive
// R13 - timing bit: 0 delayed, 1 non-delayed; ignored in gci; delayed at reset
// R14 - format bit: channels adjacent at 0, two bits apart at 1; not in gci
// R15 - seven-bit slot: receive lsb ignored, transmit lsb high impedance
// R16 - loopback retransmits captured receive byte; no coding, amplifiers muted
// R17 - latch bit 0 leaves latch pin floating, 1 pulls it low
// R18 - receive substitution decodes register byte; reads return captured byte
// R19 - transmit substitution sends the write-only register byte every frame
// R20 - voice transfer off: no decoding, transmit slots high impedance
// R21 - channel bits pick one of four gci channels; upper bit ignored in pcm
// R22 - sidetone follows its enable and is forced off when transmit input off
// R23 - routing bits send tone and speech to speaker, earpiece, both or none
// R24 - gain upper nibble sets transmit gain 0..15 dB in 1 dB steps
// R25 - gain lower nibble sets sidetone -8..-23 dB in 1 dB steps
// R26 - receive gain upper nibble sets earpiece 0..-15 dB in 1 dB steps
// R27 - receive gain lower nibble sets loudspeaker 0..-30 dB in 2 dB steps
// R28 - access is address byte then data byte; p, index, read, second-byte bits
// R29 - reset loads every field default; reserved bits read as zero
module voice_codec_control
  import voice_codec_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // mode strap
  input wire logic gci_mode,
  // serial control port pins
  input wire serial_pins_type serial_pins,
  output logic co_o,
  output logic co_oe,
  // pcm highway pins
  input wire pcm_pins_type pcm_pins,
  output logic dx_o,
  output logic dx_oe,
  // latch output pin
  output logic latch_o,
  output logic latch_oe,
  // codec core side
  input wire logic [7:0] enc_byte,
  output logic [7:0] dec_byte,
  output logic dec_valid,
  output logic tx_amp_mute,
  output logic rx_amp_mute,
  output logic power_down,
  output law_type coding_law,
  output logic [8:0] mclk_divider,
  // analog and tone controls
  output audio_ctrl_type audio_ctrl,
  output tone_clip_type tone_clip
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  localparam int unsigned PINS = 6;
  logic [PINS-1:0] pin_raw;
  logic [PINS-1:0] s1_q;
  logic [PINS-1:0] s2_q;
  logic [PINS-1:0] s3_q;
  logic [PINS-1:0] filt_q;
  logic [PINS-1:0] prev_q;

  assign pin_raw = {serial_pins, pcm_pins};

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_sync
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          s1_q[gi] <= RST_PINS[gi];
          s2_q[gi] <= RST_PINS[gi];
          s3_q[gi] <= RST_PINS[gi];
          filt_q[gi] <= RST_PINS[gi];
          prev_q[gi] <= RST_PINS[gi];
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          // accept a change once stages two and three agree
          if (s2_q[gi] == s3_q[gi]) begin
            filt_q[gi] <= s3_q[gi];
          end
          prev_q[gi] <= filt_q[gi];
        end
      end
    end
  endgenerate

  serial_pins_type ser;
  serial_pins_type ser_prev;
  pcm_pins_type pcm;
  pcm_pins_type pcm_prev;
  assign {ser, pcm} = filt_q;
  assign {ser_prev, pcm_prev} = prev_q;

  logic cclk_rise;
  logic cclk_fall;
  logic mclk_rise;
  logic mclk_fall;
  assign cclk_rise = ser.cclk & ~ser_prev.cclk & ~ser.cs_n;
  assign cclk_fall = ~ser.cclk & ser_prev.cclk & ~ser.cs_n;
  assign mclk_rise = pcm.mclk & ~pcm_prev.mclk;
  assign mclk_fall = ~pcm.mclk & pcm_prev.mclk;

  // ************************************************************
  // serial control port
  // ************************************************************
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] addr_q;
  logic [7:0] co_shift_q;
  logic [7:0] shift_d;
  logic [7:0] regs_q [NUM_REGS];
  logic [7:0] rx_capture_q;
  logic [7:0] rd_data;
  logic [3:0] addr_idx;
  logic wr_stb;
  logic [3:0] wr_idx;
  logic [7:0] wr_data;

  assign shift_d = {shift_q[6:0], ser.ci};
  assign addr_idx = addr_q[ADDR_IDX_MSB:ADDR_IDX_LSB];
  // second byte taken only when the address byte flagged one
  assign wr_stb = cclk_rise && bit_cnt_q == LAST_DATA_BIT && addr_q[ADDR_SECOND_BIT] &&
                  !addr_q[ADDR_READ_BIT]; // [R28]
  assign wr_idx = addr_idx;
  assign wr_data = shift_d;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      addr_q <= 8'h00;
      power_down <= RST_POWER_DOWN;
    end else if (ser.cs_n) begin
      bit_cnt_q <= 4'h0;
    end else if (cclk_rise) begin
      shift_q <= shift_d;
      if (bit_cnt_q != LAST_DATA_BIT) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      if (bit_cnt_q == LAST_ADDR_BIT) begin
        addr_q <= shift_d; // [R28]
        power_down <= shift_d[ADDR_POWER_BIT]; // [R28]
      end
    end
  end

  // read data from the register selected by the address byte
  always_comb begin
    rd_data = 8'h00;
    if (addr_idx == IDX_RX_SUBST) begin
      rd_data = rx_capture_q; // [R18]
    end else if (addr_idx != IDX_TX_SUBST && addr_idx < 4'(NUM_REGS)) begin
      rd_data = regs_q[addr_idx]; // [R29]
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      co_shift_q <= 8'h00;
      co_o <= 1'b0;
      co_oe <= 1'b0;
    end else if (ser.cs_n) begin
      co_oe <= 1'b0;
    end else if (cclk_rise && bit_cnt_q == LAST_ADDR_BIT) begin
      co_shift_q <= 8'h00;
    end else if (cclk_fall && bit_cnt_q == 4'h8 && addr_q[ADDR_READ_BIT] &&
                 addr_q[ADDR_SECOND_BIT] && !co_oe) begin
      co_o <= rd_data[7]; // [R12]
      co_shift_q <= {rd_data[6:0], 1'b0};
      co_oe <= 1'b1;
    end else if (cclk_fall && co_oe) begin
      co_o <= co_shift_q[7];
      co_shift_q <= {co_shift_q[6:0], 1'b0};
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= RST_OTHER; // [R29]
      end
      regs_q[IDX_CLOCK_LAW] <= RST_CLOCK_LAW; // [R29]
      regs_q[IDX_BOOST_CLIP] <= RST_BOOST_CLIP; // [R29]
    end else if (wr_stb && wr_idx < 4'(NUM_REGS)) begin
      regs_q[wr_idx] <= wr_data;
    end
  end

  logic [7:0] clk_law;
  logic [7:0] chan_path;
  logic [7:0] routing;
  logic [7:0] tone_shape;
  logic [7:0] boost_clip;
  assign clk_law = regs_q[IDX_CLOCK_LAW];
  assign chan_path = regs_q[IDX_CHANNEL_PATH];
  assign routing = regs_q[IDX_ROUTING];
  assign tone_shape = regs_q[IDX_TONE_SHAPE];
  assign boost_clip = regs_q[IDX_BOOST_CLIP];

  logic nondelayed_timing;
  logic channel_format;
  logic seven_bit_slot;
  logic digital_loopback;
  logic receive_substitute;
  logic transmit_substitute;
  logic voice_enable;
  logic channel_sel_hi;
  logic channel_sel_lo;
  assign nondelayed_timing = clk_law[3];
  assign channel_format = clk_law[2];
  assign seven_bit_slot = clk_law[1];
  assign digital_loopback = clk_law[0];
  assign receive_substitute = chan_path[4];
  assign transmit_substitute = chan_path[3];
  assign voice_enable = chan_path[2];
  assign channel_sel_hi = chan_path[1];
  assign channel_sel_lo = chan_path[0];

  // ************************************************************
  // control outputs
  // ************************************************************
  always_comb begin
    unique case (clk_law[7:6])
      2'b00: mclk_divider = DIV_512K; // [R8]
      2'b01: mclk_divider = DIV_1536K; // [R8]
      2'b10: mclk_divider = DIV_2048K; // [R8]
      2'b11: mclk_divider = DIV_2560K; // [R8]
    endcase
  end

  assign coding_law = law_type'(clk_law[5:4]); // [R11]
  assign tx_amp_mute = digital_loopback | ~routing[6]; // [R16]
  assign rx_amp_mute = digital_loopback; // [R16]
  assign latch_o = 1'b0;
  assign latch_oe = chan_path[5]; // [R17]

  always_comb begin
    audio_ctrl.mic_select = routing[7];
    audio_ctrl.transmit_input_enable = routing[6];
    audio_ctrl.sidetone_on = routing[5] & routing[6]; // [R22]
    audio_ctrl.aux_input_enable = routing[4];
    audio_ctrl.tone_to_speaker = routing[3]; // [R23]
    audio_ctrl.tone_to_earpiece = routing[2]; // [R23]
    audio_ctrl.speech_to_speaker = routing[1]; // [R23]
    audio_ctrl.speech_to_earpiece = routing[0]; // [R23]
    audio_ctrl.transmit_gain = regs_q[IDX_TX_SIDETONE][7:4]; // [R24]
    audio_ctrl.sidetone_atten = regs_q[IDX_TX_SIDETONE][3:0]; // [R25]
    audio_ctrl.earpiece_gain = regs_q[IDX_EAR_SPEAKER][7:4]; // [R26]
    audio_ctrl.speaker_gain = regs_q[IDX_EAR_SPEAKER][3:0]; // [R27]
    audio_ctrl.speaker_boost = boost_clip[7]; // [R1]
    audio_ctrl.handsfree_io_enable = chan_path[7];
    audio_ctrl.antilarsen_enable = chan_path[6];
  end

  always_comb begin
    tone_clip.tone_gain = tone_shape[7:4];
    tone_clip.tone_one_on = tone_shape[3];
    tone_clip.tone_two_on = tone_shape[2];
    tone_clip.sine_select = tone_shape[1];
    tone_clip.tone_to_transmit = tone_shape[0]; // [R7]
    tone_clip.tone_one_number = regs_q[IDX_TONE_ONE]; // [R6]
    tone_clip.tone_two_number = regs_q[IDX_TONE_TWO]; // [R6]
    tone_clip.anticlip_enable = boost_clip[6]; // [R2]
    tone_clip.clip_threshold = boost_clip[5:4]; // [R3]
    tone_clip.release_time = boost_clip[3:2]; // [R4]
    // forbidden code falls back to the standard range
    unique case (boost_clip[1:0])
      2'b01: tone_clip.tone_range = RANGE_HALF; // [R5]
      2'b10: tone_clip.tone_range = RANGE_DOUBLE; // [R5]
      default: tone_clip.tone_range = RANGE_STANDARD; // [R5]
    endcase
  end

  // ************************************************************
  // pcm slot timing
  // ************************************************************
  logic fs_seen_q;
  logic [7:0] pos_q;
  logic [7:0] pos_d;
  logic [7:0] slot_start;
  logic [8:0] rel_tx;
  logic [8:0] rel_rx;
  logic [8:0] delay_bits;
  logic in_tx_slot;
  logic in_rx_slot;

  always_comb begin
    if (gci_mode) begin
      slot_start = {3'h0, channel_sel_hi, channel_sel_lo, 3'h0}; // [R21]
    end else if (channel_sel_lo) begin
      slot_start = channel_format ? SLOT_BITS + SLOT_GAP_BITS : SLOT_BITS; // [R14] [R21]
    end else begin
      slot_start = 8'h00;
    end
    delay_bits = (gci_mode || nondelayed_timing) ? 9'h000 : 9'h001; // [R13]
    if (pcm.fs && !fs_seen_q) begin
      pos_d = 8'h00;
    end else if (pos_q != 8'hFF) begin
      pos_d = pos_q + 8'h01;
    end else begin
      pos_d = pos_q;
    end
    rel_tx = {1'b0, pos_d} - {1'b0, slot_start} - delay_bits;
    rel_rx = {1'b0, pos_q} - {1'b0, slot_start} - delay_bits;
    in_tx_slot = rel_tx[8:3] == 6'h00;
    in_rx_slot = rel_rx[8:3] == 6'h00;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pos_q <= 8'hFF;
      fs_seen_q <= 1'b0;
    end else if (mclk_rise) begin
      pos_q <= pos_d;
      fs_seen_q <= pcm.fs;
    end
  end

  // ************************************************************
  // pcm transmit
  // ************************************************************
  logic [7:0] loop_q;
  logic [7:0] tx_src;
  logic [7:0] tx_shift_q;

  always_comb begin
    if (digital_loopback) begin
      tx_src = loop_q; // [R16]
    end else if (transmit_substitute) begin
      tx_src = regs_q[IDX_TX_SUBST]; // [R19]
    end else begin
      tx_src = enc_byte;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_shift_q <= 8'h00;
      dx_o <= 1'b0;
      dx_oe <= 1'b0;
    end else if (mclk_rise) begin
      if (in_tx_slot && rel_tx[2:0] == 3'h0) begin
        dx_o <= tx_src[7]; // [R12]
        tx_shift_q <= {tx_src[6:0], 1'b0};
      end else begin
        dx_o <= tx_shift_q[7]; // [R12]
        tx_shift_q <= {tx_shift_q[6:0], 1'b0};
      end
      dx_oe <= in_tx_slot && voice_enable && // [R20]
               !(seven_bit_slot && rel_tx[2:0] == SLOT_LAST_BIT); // [R15]
    end
  end

  // ************************************************************
  // pcm receive
  // ************************************************************
  logic [6:0] rx_shift_q;
  logic [7:0] rx_byte;
  logic rx_done;
  assign rx_byte = {rx_shift_q, pcm.dr & ~seven_bit_slot}; // [R15]
  assign rx_done = mclk_fall && in_rx_slot && rel_rx[2:0] == SLOT_LAST_BIT;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_shift_q <= 7'h00;
      rx_capture_q <= 8'h00;
      loop_q <= 8'h00;
      dec_byte <= 8'h00;
      dec_valid <= 1'b0;
    end else begin
      dec_valid <= 1'b0;
      if (mclk_fall && in_rx_slot) begin
        rx_shift_q <= {rx_shift_q[5:0], pcm.dr}; // [R12]
      end
      if (rx_done) begin
        rx_capture_q <= rx_byte; // [R18]
        if (voice_enable && digital_loopback) begin
          loop_q <= rx_byte; // [R16]
        end
        if (voice_enable && !digital_loopback) begin
          dec_byte <= receive_substitute ? regs_q[IDX_RX_SUBST] : rx_byte; // [R18]
          dec_valid <= 1'b1; // [R20]
        end
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  boost_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R1]
    wr_stb && wr_idx == IDX_BOOST_CLIP |=> audio_ctrl.speaker_boost == $past(wr_data[7]))
    else $error("speaker boost did not follow write");
  anticlip_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R2]
    wr_stb && wr_idx == IDX_BOOST_CLIP |=> tone_clip.anticlip_enable == $past(wr_data[6]))
    else $error("anticlip enable did not follow write");
  range_decode_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R5]
    boost_clip[1:0] == 2'b11 |-> tone_clip.tone_range == RANGE_STANDARD)
    else $error("forbidden range not held standard");
  dx_msb_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R12]
    mclk_rise && in_tx_slot && rel_tx[2:0] == 3'h0 |=> dx_o == $past(tx_src[7]))
    else $error("transmit slot did not start with msb");
  seven_bit_lsb_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R15]
    mclk_rise && seven_bit_slot && rel_tx[2:0] == SLOT_LAST_BIT |=> !dx_oe)
    else $error("lsb driven in seven bit mode");
  voice_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R20]
    !voice_enable && !$past(voice_enable) |-> !dec_valid ##1 !dx_oe)
    else $error("voice transfer off but slot active");
  sidetone_force_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R22]
    !audio_ctrl.transmit_input_enable |-> !audio_ctrl.sidetone_on)
    else $error("sidetone on with transmit input off");
  loopback_mute_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R16]
    digital_loopback |-> tx_amp_mute && rx_amp_mute && !dec_valid)
    else $error("loopback without mute");
  rx_subst_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R18]
    rx_done && voice_enable && !digital_loopback && receive_substitute
    |=> dec_valid && dec_byte == $past(regs_q[IDX_RX_SUBST]))
    else $error("substituted receive byte not decoded");
  latch_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R17]
    wr_stb && wr_idx == IDX_CHANNEL_PATH |=> latch_oe == $past(wr_data[5]) && !latch_o)
    else $error("latch output did not follow write");

endmodule : voice_codec_control

// >>> dv/voice_ctrl_model.sv
module voice_ctrl_model
  import voice_codec_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // pins toward the block
  output serial_pins_type serial_pins,
  output pcm_pins_type pcm_pins,
  input wire logic co_o,
  input wire logic dx_o,
  input wire logic dx_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************
  // controller and highway
  // ************
  logic pwr_dn = 1'b1;
  initial begin
    serial_pins = 3'b110;
    pcm_pins = '0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick
  // address byte then data byte, msb first
  task automatic access(input logic [3:0] idx, input logic rd, input logic [7:0] wd,
                        output logic [7:0] rdata);
    logic [15:0] bits;
    bits = {pwr_dn, idx, rd, 2'b10, wd};
    serial_pins.cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_pins.cclk = 1'b0;
      serial_pins.ci = bits[i];
      tick(6);
      if (i < 8) rdata[i] = co_o;
      serial_pins.cclk = 1'b1;
      tick(6);
    end
    serial_pins.cs_n = 1'b1;
    // released line must not keep its last value
    serial_pins.ci = ~serial_pins.ci;
    tick(12);
  endtask : access
  // one frame on slot 0, msb first both ways
  task automatic frame(input logic [7:0] rx, output logic [7:0] tx, output logic [7:0] oe);
    pcm_pins.fs = 1'b1;
    tick(8);
    for (int p = 0; p < 11; p++) begin
      pcm_pins.mclk = 1'b1;
      pcm_pins.dr = (p >= 1 && p <= 8) ? rx[8 - p] : ~pcm_pins.dr;
      tick(8);
      pcm_pins.mclk = 1'b0;
      tick(4);
      pcm_pins.fs = 1'b0;
      tick(4);
      if (p >= 1 && p <= 8) begin
        tx[8 - p] = dx_o;
        oe[8 - p] = dx_oe;
      end
    end
  endtask : frame
endmodule : voice_ctrl_model

// >>> dv/voice_codec_control_tb.sv
module voice_codec_control_tb
  import voice_codec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ************
  // bench
  // ************
  localparam logic [8:0] DIVS [4] = '{DIV_512K, DIV_1536K, DIV_2048K, DIV_2560K};
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic gci_mode = 1'b0;
  logic [7:0] enc_byte = 8'h00;
  serial_pins_type serial_pins;
  pcm_pins_type pcm_pins;
  logic co_o, co_oe, dx_o, dx_oe, latch_o, latch_oe, dec_valid, tx_amp_mute;
  logic rx_amp_mute, power_down;
  logic [7:0] dec_byte, rd, tx, oe;
  logic [7:0] got_dec = 8'h00;
  law_type coding_law;
  logic [8:0] mclk_divider;
  audio_ctrl_type audio_ctrl;
  tone_clip_type tone_clip;
  int fails = 0;
  int n_compared = 0;
  initial forever #4 sys_clk = ~sys_clk;
  voice_codec_control voice_codec_control_inst (.sys_clk, .sys_rst, .gci_mode, .serial_pins,
    .co_o, .co_oe, .pcm_pins, .dx_o, .dx_oe, .latch_o, .latch_oe, .enc_byte, .dec_byte,
    .dec_valid, .tx_amp_mute, .rx_amp_mute, .power_down, .coding_law, .mclk_divider,
    .audio_ctrl, .tone_clip);
  voice_ctrl_model voice_ctrl_model_inst (.sys_clk, .serial_pins, .pcm_pins, .co_o, .dx_o,
    .dx_oe);
  always @(posedge sys_clk) if (dec_valid === 1'b1) got_dec <= dec_byte;
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    voice_ctrl_model_inst.access(idx, 1'b0, d, rd);
  endtask : wr
  task automatic rdchk(input string what, input logic [3:0] idx, input logic [7:0] exp);
    voice_ctrl_model_inst.access(idx, 1'b1, 8'h00, rd);
    check(what, rd, exp);
    check("co_oe", co_oe, 1'b0);
  endtask : rdchk
  task automatic test_defaults();
    check("power_down", power_down, 1'b1);
    check("law", coding_law, LAW_MU255);
    check("divider", mclk_divider, DIV_1536K);
    check("latch", {latch_oe, latch_o}, 2'b00);
    rdchk("clock_law", IDX_CLOCK_LAW, RST_CLOCK_LAW);
    rdchk("boost_clip", IDX_BOOST_CLIP, RST_BOOST_CLIP);
    rdchk("channel_path", IDX_CHANNEL_PATH, RST_OTHER);
    $display("test defaults done");
  endtask : test_defaults
  task automatic test_clock_law();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(IDX_CLOCK_LAW, {c, c, 4'h0});
      check("divider", mclk_divider, DIVS[c]);
      check("law", coding_law, c);
    end
    rdchk("clock_law", IDX_CLOCK_LAW, 8'hF0);
    $display("test clock_law done");
  endtask : test_clock_law
  task automatic test_regs();
    wr(IDX_ROUTING, 8'h20);
    check("sidetone", {audio_ctrl.sidetone_on, tx_amp_mute}, 2'b01);
    wr(IDX_ROUTING, 8'h6A);
    check("sidetone", {audio_ctrl.sidetone_on, tx_amp_mute}, 2'b10);
    check("routing", {audio_ctrl.tone_to_speaker, audio_ctrl.speech_to_speaker}, 2'b11);
    check("route_rest", {audio_ctrl.mic_select, audio_ctrl.aux_input_enable,
      audio_ctrl.tone_to_earpiece, audio_ctrl.speech_to_earpiece}, 4'h0);
    for (int i = 5; i < 10; i++) begin
      wr(i[3:0], {i[3:0], ~i[3:0]});
      rdchk("readback", i[3:0], {i[3:0], ~i[3:0]});
    end
    check("tone_shape", {tone_clip.tone_gain, tone_clip.tone_one_on,
      tone_clip.tone_two_on}, 6'h1E);
    check("tx_gain", {audio_ctrl.transmit_gain, audio_ctrl.sidetone_atten}, 8'h5A);
    check("ear_spk", {audio_ctrl.earpiece_gain, audio_ctrl.speaker_gain}, 8'h69);
    check("tone_one", tone_clip.tone_one_number, 8'h87);
    check("tone_two", tone_clip.tone_two_number, 8'h96);
    wr(IDX_TONE_SHAPE, 8'h03);
    check("tone_tx", {tone_clip.sine_select, tone_clip.tone_to_transmit}, 2'b11);
    // both range bits never set together
    wr(IDX_BOOST_CLIP, 8'h2E);
    check("clip", {tone_clip.clip_threshold, tone_clip.release_time}, 4'hB);
    check("range", tone_clip.tone_range, RANGE_DOUBLE);
    check("boost", {audio_ctrl.speaker_boost, tone_clip.anticlip_enable}, 2'b00);
    wr(IDX_BOOST_CLIP, 8'hC1);
    check("range", tone_clip.tone_range, RANGE_HALF);
    check("boost", {audio_ctrl.speaker_boost, tone_clip.anticlip_enable}, 2'b11);
    rdchk("unmapped", 4'hC, 8'h00);
    rdchk("write_only", IDX_TX_SUBST, 8'h00);
    $display("test regs done");
  endtask : test_regs
  task automatic test_pcm();
    enc_byte = 8'hC3;
    wr(IDX_CLOCK_LAW, 8'h40);
    voice_ctrl_model_inst.frame(8'h3C, tx, oe);
    check("dx_enc", tx, 8'hC3);
    check("dx_oe", oe, 8'h00);
    check("dec", got_dec, 8'h00);
    wr(IDX_TX_SUBST, 8'hA5);
    wr(IDX_CHANNEL_PATH, 8'h2C);
    check("latch", {audio_ctrl.handsfree_io_enable, audio_ctrl.antilarsen_enable,
      latch_oe, latch_o}, 4'h2);
    voice_ctrl_model_inst.frame(8'h3C, tx, oe);
    check("dx", tx, 8'hA5);
    check("dx_oe", oe, 8'hFF);
    check("dec", got_dec, 8'h3C);
    rdchk("rx_capture", IDX_RX_SUBST, 8'h3C);
    wr(IDX_RX_SUBST, 8'h5B);
    wr(IDX_CHANNEL_PATH, 8'h3C);
    voice_ctrl_model_inst.frame(8'h66, tx, oe);
    check("dec_subst", got_dec, 8'h5B);
    rdchk("rx_capture", IDX_RX_SUBST, 8'h66);
    wr(IDX_CLOCK_LAW, 8'h43);
    check("mute", {tx_amp_mute, rx_amp_mute}, 2'b11);
    voice_ctrl_model_inst.frame(8'h3D, tx, oe);
    check("dx_oe", oe, 8'hFE);
    voice_ctrl_model_inst.frame(8'h00, tx, oe);
    check("loop", tx, 8'h3C);
    check("dec_loop", got_dec, 8'h5B);
    voice_ctrl_model_inst.pwr_dn = 1'b0;
    wr(IDX_TONE_ONE, 8'h20);
    check("power_down", power_down, 1'b0);
    $display("test pcm done");
  endtask : test_pcm
  task automatic test_gci();
    voice_ctrl_model_inst.pwr_dn = 1'b1;
    gci_mode = 1'b1;
    wr(IDX_CLOCK_LAW, 8'h80);
    check("divider", mclk_divider, DIV_2048K);
    wr(IDX_CHANNEL_PATH, 8'h0C);
    voice_ctrl_model_inst.frame(8'h3C, tx, oe);
    check("gci_dx", tx, 8'h4A);
    check("gci_oe", oe, 8'hFE);
    $display("test gci done");
  endtask : test_gci
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk) sys_rst = 1'b0;
    repeat (8) @(negedge sys_clk);
    test_defaults();
    test_clock_law();
    test_regs();
    test_pcm();
    test_gci();
    wrap_up();
  end
  initial begin
    #400us;
    fails++;
    wrap_up();
  end
endmodule : voice_codec_control_tb
